// >>> hdl/dpll_mode_defines.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 125 MHz pclk, 32-bit APB data
// Notes:   definitions only
`ifndef DPLL_MODE_DEFINES_SVH
`define DPLL_MODE_DEFINES_SVH

// register byte offsets
`define REG_CONTROL        12'h000
`define REG_STATUS         12'h004
`define REG_DCO_WORD       12'h008
`define REG_PHASE_ERR      12'h00C

// control field positions
`define CTL_REF_SEL        0
`define CTL_MODE_LOW       1
`define CTL_MODE_HIGH      2
`define CTL_FREQ_LOW       3
`define CTL_FREQ_HIGH      4
`define CTL_FAST_LOCK      5
`define CTL_SONET          6
`define CTL_PIN_CONTROL    7
`define CTL_WIDTH          8
// freerun, SDH filtering, register control
`define CTL_RESET          8'h04

// timing: clock period and documented intervals in their own units
`define CLK_PERIOD_PS      8000
`define FRAME_PERIOD_PS    125000000
`define STORE_PERIOD_MS    30
// 15625 cycles per frame, 3750000 cycles per store interval
`define FRAME_CYCLES       (`FRAME_PERIOD_PS / `CLK_PERIOD_PS)
// per-millisecond count first, so the product stays inside 32 bits
`define CYCLES_PER_MS      (1000000000 / `CLK_PERIOD_PS)
`define STORE_CYCLES       (`STORE_PERIOD_MS * `CYCLES_PER_MS)

// reference edges per frame for each frequency select code
`define EDGES_8K           12'h001
`define EDGES_1544K        12'h0C1
`define EDGES_2048K        12'h100
`define EDGES_19440K       12'h97E

// loop constants, dco word carries 4 fraction bits
`define DCO_FRAC           4
`define ACQ_STEP           16'h0001
`define FAST_FACTOR        16'h0008
`define SONET_SLEW_STEP    16'h0004
`define LOCK_TOL           16'h0002
`define PHASE_TOL          16'h0004

`endif

// >>> hdl/dpll_mode_pkg.sv
// Purpose: shared types of the mode controller
// Assumes: nothing
// Notes:   constants live in dpll_mode_defines.svh
package dpll_mode_pkg;
  typedef enum logic [1:0] {ST_FREERUN, ST_NORMAL, ST_HOLDOVER} dpll_state_t;
  typedef logic [15:0] dco_word_t;
endpackage

// >>> hdl/holdover_if.sv
// Purpose: carrier between the loop and its holdover store
// Assumes: one clock, pclk
// Notes:   older is the slot written before the newest one
`timescale 1ns/1ps
interface holdover_if;
  import dpll_mode_pkg::*;
  logic      enable;
  dco_word_t sample;
  dco_word_t older;
  modport loop  (output enable, output sample, input older);
  modport store (input enable, input sample, output older);
endinterface

// >>> hdl/dpll_sync.sv
// Purpose: two-flop synchroniser for a group of pin levels
// Assumes: each bit is an independent level
// Notes:   only q leaves the module
`timescale 1ns/1ps
module dpll_sync #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // levels
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

// >>> hdl/dpll_holdover_store.sv
// Purpose: alternating two-slot store of the dco frequency word
// Assumes: enable is high only in Normal mode while locked
// Notes:   older holds a value 30 to 60 ms old once both slots are written
`timescale 1ns/1ps
`include "dpll_mode_defines.svh"
module dpll_holdover_store
  import dpll_mode_pkg::*;
#(
  parameter int STORE_CYCLES = `STORE_CYCLES
) (
  // clock and reset
  input  wire logic  pclk,
  input  wire logic  presetn,
  // loop side
  holdover_if.store  hold
);
  logic [31:0] timer;
  dco_word_t   slot [2];
  logic        newest;
  wire         store_tick = hold.enable && (timer == 32'(STORE_CYCLES - 1));

  // the timer clears outside lock so stale values never enter a slot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer <= '0;
    end else if (!hold.enable || store_tick) begin
      timer <= '0;
    end else begin
      timer <= timer + 32'd1;
    end
  end

  // alternate slots every interval
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot[0] <= '0;
      slot[1] <= '0;
      newest  <= 1'b0;
    end else if (store_tick) begin
      slot[~newest] <= hold.sample;
      newest        <= ~newest;
    end
  end

  // the slot not written last is the older sample
  assign hold.older = slot[~newest];
endmodule

// >>> hdl/dpll_mode_control.sv
// Purpose: mode, reference and holdover control of the synchronizing loop
// Assumes: references and control pins are asynchronous to pclk
// Notes:   the loop is a per-frame edge-count model with a fractional word
`timescale 1ns/1ps
`include "dpll_mode_defines.svh"
module dpll_mode_control
  import dpll_mode_pkg::*;
#(
  parameter int FRAME_CYCLES = `FRAME_CYCLES,
  parameter int STORE_CYCLES = `STORE_CYCLES
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // references and hardware control pins
  input  wire logic        primary_reference,
  input  wire logic        secondary_reference,
  input  wire logic        pin_control,
  input  wire logic        reference_select,
  input  wire logic        mode_select_low,
  input  wire logic        mode_select_high,
  input  wire logic        freq_select_low,
  input  wire logic        freq_select_high,
  // timing and status
  output logic             frame_pulse_out_8k,
  output dco_word_t        dco_word,
  output logic             locked,
  output logic             reference_active,
  output dpll_state_t      state
);
  // magnitude of a signed difference, used for frequency and phase
  function automatic logic [15:0] magnitude(input logic signed [19:0] v);
    logic [19:0] a;
    a = v[19] ? 20'(-v) : v;
    return (a[19:16] != 4'h0) ? 16'hFFFF : a[15:0];
  endfunction

  holdover_if hold ();

  logic [7:0]            pins;
  logic                  ref_prev;
  logic [`CTL_WIDTH-1:0] control;
  logic [31:0]           frame_cnt;
  logic [11:0]           edge_cnt;
  logic [11:0]           measured;
  logic signed [19:0]    phase_err;
  logic                  slope_limited;

  dpll_sync #(
    .WIDTH (8)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({freq_select_high, freq_select_low, mode_select_high, mode_select_low,
               reference_select, pin_control, secondary_reference, primary_reference}),
    .q       (pins)
  );

  dpll_holdover_store #(
    .STORE_CYCLES (STORE_CYCLES)
  ) u_store (
    .pclk    (pclk),
    .presetn (presetn),
    .hold    (hold.store)
  );

  // control source: pins when the strap or the control bit asks for it
  wire       use_pins  = pins[2] | control[`CTL_PIN_CONTROL];
  wire       req_ref   = use_pins ? pins[3] : control[`CTL_REF_SEL];
  wire [1:0] req_mode  = use_pins ? pins[5:4]
                       : {control[`CTL_MODE_HIGH], control[`CTL_MODE_LOW]};
  wire [1:0] req_freq  = use_pins ? pins[7:6]
                       : {control[`CTL_FREQ_HIGH], control[`CTL_FREQ_LOW]};
  wire       fast_lock = control[`CTL_FAST_LOCK];
  wire       sonet     = control[`CTL_SONET];

  // expected edges per frame from the frequency select pair
  wire [11:0] expected = (req_freq == 2'b00) ? `EDGES_8K
                       : (req_freq == 2'b01) ? `EDGES_1544K
                       : (req_freq == 2'b10) ? `EDGES_2048K
                       : `EDGES_19440K;
  wire dco_word_t nominal = {expected, 4'h0};

  // selected reference, blanked in Freerun so no edge is ever counted
  wire ref_now  = reference_active ? pins[1] : pins[0];
  wire ref_edge = ref_now && !ref_prev && (state == ST_NORMAL);
  wire frame_tick = (frame_cnt == 32'(FRAME_CYCLES - 1));

  // loop step: fast lock multiplies the step, SONET caps the slope
  wire dco_word_t target   = {measured, 4'h0};
  wire logic signed [19:0] freq_diff = 20'($signed({4'h0, target}))
                                     - 20'($signed({4'h0, dco_word}));
  wire dco_word_t freq_mag = magnitude(freq_diff);
  wire dco_word_t fast_step = `ACQ_STEP * `FAST_FACTOR;
  wire dco_word_t step_raw = fast_lock ? fast_step : `ACQ_STEP;
  wire dco_word_t step     = (fast_lock && sonet && step_raw > `SONET_SLEW_STEP)
                           ? `SONET_SLEW_STEP : step_raw;
  wire limited = (freq_mag > step);
  wire dco_word_t next_dco = !limited ? target
                           : (freq_diff[19] ? dco_word - step : dco_word + step);
  wire logic signed [19:0] phase_step = 20'($signed({8'h00, measured}))
                                      - 20'($signed({8'h00, dco_word[15:`DCO_FRAC]}));
  wire logic signed [19:0] next_phase = phase_err + phase_step;
  wire next_locked = (freq_mag <= `LOCK_TOL) && !limited
                   && (magnitude(next_phase) <= `PHASE_TOL);

  // apb decode
  wire access  = psel && penable;
  wire wr_take = access && pready && pwrite;
  wire hit_ctl = (paddr == `REG_CONTROL);
  wire hit_sta = (paddr == `REG_STATUS);
  wire hit_dco = (paddr == `REG_DCO_WORD);
  wire hit_phs = (paddr == `REG_PHASE_ERR);
  wire mapped  = hit_ctl || hit_sta || hit_dco || hit_phs;
  logic [31:0] rd_mux;
  always_comb begin
    if (hit_ctl) begin
      rd_mux = {24'h000000, control};
    end else if (hit_sta) begin
      rd_mux = {27'h0000000, slope_limited, locked, reference_active, state};
    end else if (hit_dco) begin
      rd_mux = {16'h0000, dco_word};
    end else if (hit_phs) begin
      rd_mux = {{12{phase_err[19]}}, phase_err};
    end else begin
      rd_mux = 32'h00000000;
    end
  end

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= access && !pready;
      pslverr <= access && !pready && !mapped;
      prdata  <= (access && !pready && !pwrite) ? rd_mux : 32'h00000000;
    end
  end

  // control register, status registers are read only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control <= `CTL_RESET;
    end else if (wr_take && hit_ctl) begin
      control <= pwdata[`CTL_WIDTH-1:0];
    end
  end

  // frame timebase from the master clock; the pulse is a flop output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_cnt          <= '0;
      frame_pulse_out_8k <= 1'b0;
    end else begin
      frame_cnt          <= frame_tick ? 32'd0 : frame_cnt + 32'd1;
      frame_pulse_out_8k <= frame_tick;
    end
  end

  // reference edges counted over one frame window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_prev <= 1'b0;
      edge_cnt <= '0;
      measured <= '0;
    end else begin
      ref_prev <= ref_now;
      if (frame_tick) begin
        measured <= edge_cnt;
        edge_cnt <= 12'(ref_edge);
      end else if (ref_edge && edge_cnt != 12'hFFF) begin
        edge_cnt <= edge_cnt + 12'd1;
      end
    end
  end

  // mode and reference take effect only with the frame pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state            <= ST_FREERUN;
      reference_active <= 1'b0;
    end else if (frame_tick) begin
      if (req_mode != 2'b11) begin
        reference_active <= req_ref;
      end
      case (req_mode)
        2'b00: state <= ST_NORMAL;
        2'b01: state <= (state == ST_FREERUN) ? ST_FREERUN : ST_HOLDOVER;
        2'b10: state <= ST_FREERUN;
        default: state <= state;
      endcase
    end
  end

  // dco word, phase error and lock, updated once per frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dco_word      <= '0;
      phase_err     <= '0;
      locked        <= 1'b0;
      slope_limited <= 1'b0;
    end else if (frame_tick) begin
      case (state)
        ST_NORMAL: begin
          dco_word      <= next_dco;
          phase_err     <= next_phase;
          locked        <= next_locked;
          slope_limited <= limited;
        end
        ST_HOLDOVER: begin
          // word frozen at the stored sample, so no drift beyond the master clock
          dco_word      <= dco_word;
          phase_err     <= '0;
          locked        <= 1'b0;
          slope_limited <= 1'b0;
        end
        default: begin
          dco_word      <= nominal;
          phase_err     <= '0;
          locked        <= 1'b0;
          slope_limited <= 1'b0;
        end
      endcase
      // entry into holdover loads the older slot, never the newest sample
      if (state == ST_NORMAL && req_mode == 2'b01) begin
        dco_word  <= hold.older;
        phase_err <= '0;
        locked    <= 1'b0;
      end
    end
  end

  // store only while locked in Normal mode
  assign hold.enable = locked && (state == ST_NORMAL);
  assign hold.sample = dco_word;
endmodule

// >>> tb/dpll_mode_control_monitor.sv
// Purpose: port assertions of the mode controller
// Assumes: one clock domain, pclk
// Notes:   slow outputs may only move together with the frame pulse
`timescale 1ns/1ps
module dpll_mode_control_monitor
  import dpll_mode_pkg::*;
#(
  parameter int FRAME_CYCLES = 64,
  parameter int STORE_CYCLES = 4
) (
  // clock and reset
  input wire logic   pclk,
  input wire logic   presetn,
  // apb handshake
  input wire logic   psel,
  input wire logic   penable,
  input wire logic   pready,
  // timing and status
  input wire logic   frame_pulse_out_8k,
  input dco_word_t   dco_word,
  input wire logic   locked,
  input wire logic   reference_active,
  input dpll_state_t state
);
  int   gap;
  logic seen;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // cycles since the last pulse; the first frame after reset is not timed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap  <= 0;
      seen <= 1'b0;
    end else begin
      gap  <= frame_pulse_out_8k ? 1 : gap + 1;
      seen <= seen | frame_pulse_out_8k;
    end
  end
  a_frame_period:
    assert property (seen |-> (gap == FRAME_CYCLES) == frame_pulse_out_8k)
    else $error("frame pulse spacing wrong");
  a_state_legal: assert property (state != 2'h3)
    else $error("reserved state code driven");
  a_state_at_frame: assert property ($changed(state) |-> frame_pulse_out_8k)
    else $error("state moved off the frame pulse");
  a_ref_at_frame:
    assert property ($changed(reference_active) |-> frame_pulse_out_8k)
    else $error("reference moved off the frame pulse");
  a_no_hold_free:
    assert property ($past(state) == ST_FREERUN |-> state != ST_HOLDOVER)
    else $error("holdover entered from freerun");
  a_dco_at_frame: assert property ($changed(dco_word) |-> frame_pulse_out_8k)
    else $error("dco word moved off the frame pulse");
  a_lock_at_frame: assert property ($changed(locked) |-> frame_pulse_out_8k)
    else $error("lock moved off the frame pulse");
  a_normal_step:
    assert property (state == ST_NORMAL && $past(state) == ST_NORMAL && $changed(dco_word)
      |-> (dco_word - $past(dco_word) <= 16'h0008) || ($past(dco_word) - dco_word <= 16'h0008))
    else $error("dco step above the fast step");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("ready not one cycle after access");
endmodule

bind dpll_mode_control dpll_mode_control_monitor #(
  .FRAME_CYCLES(FRAME_CYCLES), .STORE_CYCLES(STORE_CYCLES)
) i_dpll_mode_control_monitor (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .frame_pulse_out_8k(frame_pulse_out_8k), .dco_word(dco_word), .locked(locked),
  .reference_active(reference_active), .state(state)
);

// >>> tb/dpll_ref_net.sv
// Purpose: network reference clocks seen by the mode controller
// Assumes: both references share one rate
// Notes:   a half period of 0 models a lost reference, its line sits low
`timescale 1ns/1ps
module dpll_ref_net (
  // rate set by the bench
  input  var int half_ns,
  // network references
  output logic   primary_reference,
  output logic   secondary_reference
);
  initial primary_reference = 1'b0;
  initial secondary_reference = 1'b0;
  // toggle at the requested rate
  always begin
    #(half_ns > 0 ? half_ns : 8);
    primary_reference = (half_ns > 0) ? ~primary_reference : 1'b0;
  end
  // trailing copy, so a reference switch also moves the phase
  always @(primary_reference) secondary_reference <= #100 primary_reference;
endmodule

// >>> tb/testbench.sv
// Purpose: self-checking bench of the mode controller
// Assumes: frame of 64 cycles, store interval of 4
// Notes:   read answers are compared against a queue of notes
`timescale 1ns/1ps
`include "dpll_mode_defines.svh"
module testbench
  import dpll_mode_pkg::*;
;
  localparam int FRAMES = 64;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, locked;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rnd;
  logic        pin_control, reference_select, mode_select_low, mode_select_high;
  logic        freq_select_low, freq_select_high, primary_reference, secondary_reference;
  logic        frame_pulse_out_8k, reference_active;
  dco_word_t   dco_word;
  dpll_state_t state;
  int          half_ns, error_cnt, tests_run;
  int          cycles = 0;
  logic [64:0] expq[$];
  logic [11:0] nom[4] = '{`EDGES_8K, `EDGES_1544K, `EDGES_2048K, `EDGES_19440K};

  initial pclk = 1'b0;
  always #4 pclk = ~pclk;

  dpll_mode_control #(.FRAME_CYCLES(FRAMES), .STORE_CYCLES(4)) i_dpll_mode_control (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .primary_reference(primary_reference), .secondary_reference(secondary_reference),
    .pin_control(pin_control), .reference_select(reference_select),
    .mode_select_low(mode_select_low), .mode_select_high(mode_select_high),
    .freq_select_low(freq_select_low), .freq_select_high(freq_select_high),
    .frame_pulse_out_8k(frame_pulse_out_8k), .dco_word(dco_word), .locked(locked),
    .reference_active(reference_active), .state(state)
  );
  dpll_ref_net i_dpll_ref_net (
    .half_ns(half_ns), .primary_reference(primary_reference),
    .secondary_reference(secondary_reference)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic end_of_test;
    if (error_cnt == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask

  // request held until ready is seen high at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      error_cnt++;
      $display("MISMATCH pready exp 1 got %b", pready);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m,
                    input logic er = 1'b0);
    expq.push_back({er, m, e});
    apb(1'b0, a, 32'h0);
  endtask

  task automatic frames(input int n);
    repeat (n) @(posedge frame_pulse_out_8k);
    @(posedge pclk);
  endtask

  task automatic wait_lock;
    repeat (40) if (locked !== 1'b1) frames(1);
  endtask

  // dco change over one frame once the new pace is in force
  task automatic slope(input logic [31:0] e);
    logic [15:0] a;
    frames(2);
    a = dco_word;
    frames(1);
    chk("dco step", e, {16'h0, a - dco_word});
  endtask

  // compare each read answer with the oldest note
  always @(posedge pclk) begin
    logic [64:0] note;
    if (psel && penable && !pwrite && pready === 1'b1 && expq.size() > 0) begin
      note = expq.pop_front();
      chk($sformatf("read %h", paddr), note[31:0], prdata & note[63:32]);
      chk("pslverr", {31'h0, note[64]}, {31'h0, pslverr});
    end
  end

  // hang guard
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 30000) begin
      error_cnt++;
      end_of_test();
    end
  end

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; pin_control = 1'b0; reference_select = 1'b0;
    {mode_select_high, mode_select_low, freq_select_high, freq_select_low} = 4'h0;
    half_ns = FRAMES * 4;
    error_cnt = 0; tests_run = 0; rnd = 32'h00010A24;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(`REG_CONTROL, 32'h04, 32'hFF);
    rd(`REG_STATUS, 32'h0, 32'h7);
    rd(12'h010, 32'h0, 32'hFFFFFFFF, 1'b1);
    repeat (4) begin
      rnd = lfsr(rnd);
      wr(`REG_CONTROL, rnd);
      rd(`REG_CONTROL, {24'h0, rnd[7:0]}, 32'hFFFFFFFF);
    end
    // freerun word follows the frequency code, references running meanwhile
    for (int i = 0; i < 4; i++) begin
      wr(`REG_CONTROL, 32'h04 | (i << 3));
      frames(3);
      rd(`REG_DCO_WORD, {16'h0, nom[i], 4'h0}, 32'hFFFF);
    end
    // acquisition pace from a far word: fast, fast with sonet, ordinary
    // keep the fastest rate code so the freerun word stays far from the target
    wr(`REG_CONTROL, 32'h38);
    slope(32'h8);
    wr(`REG_CONTROL, 32'h78);
    slope(32'h4);
    wr(`REG_CONTROL, 32'h18);
    slope(32'h1);
    wr(`REG_CONTROL, 32'h04);
    frames(3);
    wr(`REG_CONTROL, 32'h00);
    wait_lock();
    rd(`REG_STATUS, 32'h9, 32'hF);
    wr(`REG_CONTROL, 32'h40);
    wr(`REG_CONTROL, 32'h41);
    frames(2);
    rd(`REG_STATUS, 32'h5, 32'h7);
    wr(`REG_CONTROL, 32'h47);
    frames(2);
    rd(`REG_STATUS, 32'h5, 32'h7);
    wait_lock();
    frames(2);
    wr(`REG_CONTROL, 32'h43);
    frames(2);
    rd(`REG_STATUS, 32'h6, 32'h7);
    rd(`REG_DCO_WORD, 32'h10, 32'hFFFF);
    rd(`REG_PHASE_ERR, 32'h0, 32'hFFFFFFFF);
    half_ns = 0;
    frames(3);
    rd(`REG_DCO_WORD, 32'h10, 32'hFFFF);
    half_ns = FRAMES * 4;
    wr(`REG_CONTROL, 32'h61);
    frames(2);
    wr(`REG_CONTROL, 32'h63);
    frames(2);
    wr(`REG_CONTROL, 32'h61);
    wait_lock();
    rd(`REG_STATUS, 32'hD, 32'hF);
    wr(`REG_CONTROL, 32'h41);
    // strap hands control to the pins: freerun at the third rate, then normal
    {mode_select_high, mode_select_low, freq_select_high, freq_select_low} <= 4'hA;
    pin_control <= 1'b1;
    frames(3);
    rd(`REG_STATUS, 32'h0, 32'h7);
    rd(`REG_DCO_WORD, {16'h0, `EDGES_2048K, 4'h0}, 32'hFFFF);
    {mode_select_high, mode_select_low, reference_select} <= 3'h1;
    frames(3);
    rd(`REG_STATUS, 32'h5, 32'h7);
    @(posedge pclk);
    end_of_test();
  end
endmodule
